// ===== hw/sbp_pkg.sv
// Shared types and constants for the call-branch and system-control
// pipeline sequencer.
// Assumes a single core clock and an upstream decoder that classifies
// each instruction before it reaches ID.
package sbp_pkg;

	// ------------------------------------------------------------
	// Widths and timing counts
	// ------------------------------------------------------------
	localparam int unsigned CNT_W = 3;
	localparam int unsigned REG_W = 4;

	// Extra EX slots after the first, loaded as count minus one
	localparam logic [CNT_W-1:0] STAT_REG_TAIL_LOAD = 3'h1;
	localparam logic [CNT_W-1:0] STAT_MEM_TAIL_LOAD = 3'h2;

	// ID slots lost after a DSP-variant control load
	localparam logic [CNT_W-1:0] DSP_ALU_DELAY = 3'h2;
	localparam logic [CNT_W-1:0] DSP_MEM_DELAY = 3'h4;

	localparam logic [CNT_W-1:0] CNT_RST = 3'h0;

	// ------------------------------------------------------------
	// Instruction classes seen by the sequencer
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		CLS_NOP           = 4'h0,
		CLS_CALL_PCREL    = 4'h1,
		CLS_CALL_PCREG    = 4'h2,
		CLS_CALL_IND      = 4'h3,
		CLS_CTL_ALU       = 4'h4,
		CLS_SYS_ALU       = 4'h5,
		CLS_LOOP_LOAD     = 4'h6,
		CLS_FLAG_OP       = 4'h7,
		CLS_TLB_LOAD      = 4'h8,
		CLS_STAT_LOAD_REG = 4'h9,
		CLS_STAT_LOAD_MEM = 4'ha,
		CLS_RA_LOAD_MEM   = 4'hb,
		CLS_CTL_LOAD_MEM  = 4'hc,
		CLS_RA_STORE_MEM  = 4'hd,
		CLS_OTHER         = 4'he
	} sbp_cls_e;

	// Write-back destination kinds
	typedef enum logic [2:0] {
		WBK_GPR  = 3'h0,
		WBK_RA   = 3'h1,
		WBK_CTL  = 3'h2,
		WBK_STAT = 3'h3,
		WBK_PTR  = 3'h4
	} sbp_wbk_e;

	// Long status-register load sequencer states
	typedef enum logic [2:0] {
		SEQ_RUN     = 3'b001,
		SEQ_STAT_MA = 3'b010,
		SEQ_STAT_EX = 3'b100
	} sbp_seq_e;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic             valid;
		sbp_cls_e         cls;
		logic [REG_W-1:0] dst;
		logic [REG_W-1:0] ptr;
		logic [REG_W-1:0] src_a;
		logic [REG_W-1:0] src_b;
		logic             reads_stat;
	} sbp_instr_s;

	typedef struct packed {
		logic             req;
		logic             write;
		logic [REG_W-1:0] ptr;
	} sbp_ma_s;

	typedef struct packed {
		logic             en;
		sbp_wbk_e         kind;
		logic [REG_W-1:0] idx;
	} sbp_wb_s;

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
	} sbp_cnt_s;

	typedef struct packed {
		sbp_seq_e   seq;
		sbp_instr_s ex;
		sbp_instr_s ma;
		sbp_instr_s wb;
	} sbp_state_s;

	localparam sbp_instr_s INSTR_BUBBLE = '0;

endpackage

// ===== hw/sbp_slot_cnt.sv
// Down-counter of pipeline slots, used for ID delays and EX tails.
// Assumes load_i is a one-cycle request from logic on the same clock.
`timescale 1ns/1ns
`default_nettype none

module sbp_slot_cnt (
	input  wire logic                       ref_clk_i,
	input  wire logic                       rst_i,
	input  wire logic                       load_i,
	input  wire logic [sbp_pkg::CNT_W-1:0] val_i,
	output logic                            busy_o,
	output logic      [sbp_pkg::CNT_W-1:0] cnt_o
);

	sbp_pkg::sbp_cnt_s s_q;
	sbp_pkg::sbp_cnt_s s_d;

	// ------------------------------------------------------------
	// Next count
	// ------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		if (load_i) begin
			s_d.cnt = val_i;
		end else if (s_q.cnt != sbp_pkg::CNT_RST) begin
			s_d.cnt = s_q.cnt - 3'h1;
		end
	end

	// Count register
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			s_q.cnt <= sbp_pkg::CNT_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs
	assign busy_o = (s_q.cnt != sbp_pkg::CNT_RST);
	assign cnt_o  = s_q.cnt;

endmodule

`default_nettype wire

// ===== hw/sbp_pipe_ctl.sv
// Stage sequencer for call branches and system-control instructions.
// Assumes a decoder presents one classified instruction at ID and holds
// it until id_ready_o; the fetch path obeys if_en_o, redirect_o and
// discard_o; the memory path serves ma_o in the slot it is raised.
//
// How it works
// - Calls run IF ID EX MA WB; the delay-slot instruction executes.
// - The instruction fetched second after a call is discarded.
// - Target fetch starts in the slot right after the call's EX.
// - Register control/system moves compute in EX, hold in MA, write in WB.
// - DSP mode: control, loop or repeat loads delay next ID two slots.
// - Flag set/clear ops hold data through MA, write status in WB.
// - Status readers within two after a flag op are stalled.
// - Translation-entry load has no WB; its MA beats instruction fetch.
// - No-op uses IF, ID, EX only.
// - Status load from register: three EX slots, written in the last.
// - Status load from memory: EX, MA, three EX, written in the last.
// - After a status load, fetch resumes only after the final EX.
// - Memory loads of procedure/control registers interlock a dependent next instruction.
// - Procedure/control register memory MA wins over a concurrent fetch.
// - Procedure register store with pre-decrement writes the new pointer in WB.
// - DSP mode: control load from memory delays next ID four slots.
`timescale 1ns/1ns
`default_nettype none

module sbp_pipe_ctl (
	input  wire logic                ref_clk_i,
	input  wire logic                rst_i,
	input  wire logic                dsp_mode_i,
	input  wire sbp_pkg::sbp_instr_s id_instr_i,
	output logic                     id_ready_o,
	output logic                     if_en_o,
	output logic                     redirect_o,
	output logic                     discard_o,
	output logic                     interlock_o,
	output logic                     stat_write_o,
	output var sbp_pkg::sbp_ma_s     ma_o,
	output var sbp_pkg::sbp_wb_s     wb_o
);

	// ------------------------------------------------------------
	// Class helpers
	// ------------------------------------------------------------

	// Branches that save the return address
	function automatic logic is_call(input sbp_pkg::sbp_cls_e c);
		is_call = (c == sbp_pkg::CLS_CALL_PCREL) ||
			(c == sbp_pkg::CLS_CALL_PCREG) ||
			(c == sbp_pkg::CLS_CALL_IND);
	endfunction

	// Long status-register loads
	function automatic logic is_stat_load(input sbp_pkg::sbp_cls_e c);
		is_stat_load = (c == sbp_pkg::CLS_STAT_LOAD_REG) ||
			(c == sbp_pkg::CLS_STAT_LOAD_MEM);
	endfunction

	// Loads whose result arrives at end of MA
	function automatic logic is_mem_load(input sbp_pkg::sbp_cls_e c);
		is_mem_load = (c == sbp_pkg::CLS_RA_LOAD_MEM) ||
			(c == sbp_pkg::CLS_CTL_LOAD_MEM);
	endfunction

	// Classes that own an MA slot
	function automatic logic has_ma(input sbp_pkg::sbp_cls_e c);
		has_ma = (c != sbp_pkg::CLS_NOP) && !is_stat_load(c);
	endfunction

	// Classes that own a WB slot
	function automatic logic has_wb(input sbp_pkg::sbp_cls_e c);
		has_wb = has_ma(c) && (c != sbp_pkg::CLS_TLB_LOAD);
	endfunction

	// Classes whose MA really touches the memory path
	function automatic logic uses_mem(input sbp_pkg::sbp_cls_e c);
		uses_mem = (c == sbp_pkg::CLS_TLB_LOAD) ||
			(c == sbp_pkg::CLS_RA_LOAD_MEM) ||
			(c == sbp_pkg::CLS_CTL_LOAD_MEM) ||
			(c == sbp_pkg::CLS_RA_STORE_MEM);
	endfunction

	// Destination kind written in WB
	function automatic sbp_pkg::sbp_wbk_e wb_kind(input sbp_pkg::sbp_cls_e c);
		case (c)
			sbp_pkg::CLS_CALL_PCREL,
			sbp_pkg::CLS_CALL_PCREG,
			sbp_pkg::CLS_CALL_IND,
			sbp_pkg::CLS_RA_LOAD_MEM:  wb_kind = sbp_pkg::WBK_RA;
			sbp_pkg::CLS_CTL_ALU,
			sbp_pkg::CLS_LOOP_LOAD,
			sbp_pkg::CLS_CTL_LOAD_MEM: wb_kind = sbp_pkg::WBK_CTL;
			sbp_pkg::CLS_FLAG_OP:      wb_kind = sbp_pkg::WBK_STAT;
			sbp_pkg::CLS_RA_STORE_MEM: wb_kind = sbp_pkg::WBK_PTR;
			default:                   wb_kind = sbp_pkg::WBK_GPR;
		endcase
	endfunction

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	sbp_pkg::sbp_state_s s_q;
	sbp_pkg::sbp_state_s s_d;

	logic                      ex_live;
	logic                      call_ex;
	logic                      flag_hz;
	logic                      lu_hz;
	logic                      stat_busy;
	logic                      id_hold;
	logic                      id_fire;
	logic                      fetch_hold;
	logic                      ma_mem;
	logic                      stat_last;
	logic                      dsp_load;
	logic [sbp_pkg::CNT_W-1:0] dsp_val;
	logic                      dsp_busy;
	logic                      tail_load;
	logic [sbp_pkg::CNT_W-1:0] tail_val;
	logic [sbp_pkg::CNT_W-1:0] tail_cnt;

	// ------------------------------------------------------------
	// Slot counters
	// ------------------------------------------------------------

	// ID delay after DSP-variant control loads
	sbp_slot_cnt u_dsp_delay (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.load_i    (dsp_load),
		.val_i     (dsp_val),
		.busy_o    (dsp_busy),
		.cnt_o     ()
	);

	// Trailing EX slots of status loads
	sbp_slot_cnt u_stat_tail (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.load_i    (tail_load),
		.val_i     (tail_val),
		.busy_o    (),
		.cnt_o     (tail_cnt)
	);

	// ------------------------------------------------------------
	// Hazards and stalls
	// ------------------------------------------------------------

	// Instruction sitting in EX
	assign ex_live = s_q.ex.valid;

	// Call in its EX slot redirects fetch
	assign call_ex = ex_live && is_call(s_q.ex.cls);

	// Status reader behind a pending flag write
	assign flag_hz = id_instr_i.valid && id_instr_i.reads_stat &&
		((ex_live && s_q.ex.cls == sbp_pkg::CLS_FLAG_OP) ||
		(s_q.ma.valid && s_q.ma.cls == sbp_pkg::CLS_FLAG_OP));

	// Next instruction reads a register still being loaded
	assign lu_hz = id_instr_i.valid && ex_live && is_mem_load(s_q.ex.cls) &&
		((id_instr_i.src_a == s_q.ex.dst) ||
		(id_instr_i.src_b == s_q.ex.dst));

	// Status load occupies EX
	assign stat_busy = (s_q.seq != sbp_pkg::SEQ_RUN) ||
		(ex_live && is_stat_load(s_q.ex.cls));

	// Final EX slot of a status load
	assign stat_last = (s_q.seq == sbp_pkg::SEQ_STAT_EX) &&
		(tail_cnt == sbp_pkg::CNT_RST);

	// ID stall sources
	assign id_hold = call_ex || dsp_busy || stat_busy || flag_hz || lu_hz;
	assign id_fire = id_instr_i.valid && !id_hold;

	// No fetch from status load's ID through its final EX
	assign fetch_hold = stat_busy ||
		(id_instr_i.valid && is_stat_load(id_instr_i.cls));

	// Memory slot in use this cycle
	assign ma_mem = (s_q.ma.valid && uses_mem(s_q.ma.cls)) ||
		(s_q.seq == sbp_pkg::SEQ_STAT_MA);

	// ------------------------------------------------------------
	// DSP-variant ID delay requests
	// ------------------------------------------------------------
	always_comb begin
		dsp_load = 1'b0;
		dsp_val  = sbp_pkg::CNT_RST;
		if (id_fire && dsp_mode_i) begin
			case (id_instr_i.cls)
				sbp_pkg::CLS_CTL_ALU,
				sbp_pkg::CLS_LOOP_LOAD: begin
					dsp_load = 1'b1;
					dsp_val  = sbp_pkg::DSP_ALU_DELAY;
				end
				sbp_pkg::CLS_CTL_LOAD_MEM: begin
					dsp_load = 1'b1;
					dsp_val  = sbp_pkg::DSP_MEM_DELAY;
				end
				default: begin
					dsp_load = 1'b0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Stage advance and status-load sequencing
	// ------------------------------------------------------------
	always_comb begin
		s_d       = s_q;
		tail_load = 1'b0;
		tail_val  = sbp_pkg::CNT_RST;

		// Normal flow: ID to EX, EX to MA, MA to WB
		s_d.ex = id_fire ? id_instr_i : sbp_pkg::INSTR_BUBBLE;
		s_d.ma = sbp_pkg::INSTR_BUBBLE;
		if (ex_live && has_ma(s_q.ex.cls)) begin
			s_d.ma = s_q.ex;
		end
		s_d.wb = sbp_pkg::INSTR_BUBBLE;
		if (s_q.ma.valid && has_wb(s_q.ma.cls)) begin
			s_d.wb = s_q.ma;
		end

		case (s_q.seq)
			sbp_pkg::SEQ_RUN: begin
				if (ex_live && s_q.ex.cls == sbp_pkg::CLS_STAT_LOAD_REG) begin
					s_d.ex    = s_q.ex;
					s_d.seq   = sbp_pkg::SEQ_STAT_EX;
					tail_load = 1'b1;
					tail_val  = sbp_pkg::STAT_REG_TAIL_LOAD;
				end else if (ex_live && s_q.ex.cls == sbp_pkg::CLS_STAT_LOAD_MEM) begin
					s_d.ex  = s_q.ex;
					s_d.seq = sbp_pkg::SEQ_STAT_MA;
				end
			end
			sbp_pkg::SEQ_STAT_MA: begin
				s_d.ex    = s_q.ex;
				s_d.seq   = sbp_pkg::SEQ_STAT_EX;
				tail_load = 1'b1;
				tail_val  = sbp_pkg::STAT_MEM_TAIL_LOAD;
			end
			sbp_pkg::SEQ_STAT_EX: begin
				if (stat_last) begin
					s_d.ex  = sbp_pkg::INSTR_BUBBLE;
					s_d.seq = sbp_pkg::SEQ_RUN;
				end else begin
					s_d.ex = s_q.ex;
				end
			end
			default: begin
				s_d.seq = sbp_pkg::SEQ_RUN;
			end
		endcase
	end

	// Stage registers
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			s_q.seq <= sbp_pkg::SEQ_RUN;
			s_q.ex  <= sbp_pkg::INSTR_BUBBLE;
			s_q.ma  <= sbp_pkg::INSTR_BUBBLE;
			s_q.wb  <= sbp_pkg::INSTR_BUBBLE;
		end else begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------
	// Fetch-side outputs
	// ------------------------------------------------------------

	// ID accept and fetch permission
	assign id_ready_o  = !id_hold;
	assign if_en_o     = !fetch_hold && !ma_mem;
	assign interlock_o = lu_hz;

	// Target fetch next slot; this slot's fetch is dropped
	assign redirect_o = call_ex;
	assign discard_o  = call_ex;

	// ------------------------------------------------------------
	// Memory access port
	// ------------------------------------------------------------
	always_comb begin
		ma_o.req   = ma_mem;
		ma_o.write = s_q.ma.valid && s_q.ma.cls == sbp_pkg::CLS_RA_STORE_MEM;
		ma_o.ptr   = s_q.ma.ptr;
		if (s_q.seq == sbp_pkg::SEQ_STAT_MA) begin
			ma_o.ptr = s_q.ex.ptr;
		end
	end

	// ------------------------------------------------------------
	// Write-back port
	// ------------------------------------------------------------
	always_comb begin
		wb_o.en   = s_q.wb.valid;
		wb_o.kind = wb_kind(s_q.wb.cls);
		wb_o.idx  = s_q.wb.dst;
		if (s_q.wb.cls == sbp_pkg::CLS_RA_STORE_MEM) begin
			wb_o.idx = s_q.wb.ptr;
		end
	end

	// Status register written by flag ops in WB or status loads in last EX
	assign stat_write_o = stat_last ||
		(s_q.wb.valid && s_q.wb.cls == sbp_pkg::CLS_FLAG_OP);

endmodule

`default_nettype wire

// ===== sim/sbp_pipe_ctl_assertions.sv
// Port-level checks for the call and system-control sequencer.
// Assumes one core clock and a synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none

module sbp_pipe_ctl_assertions (
	input wire logic                ref_clk_i,
	input wire logic                rst_i,
	input wire logic                dsp_mode_i,
	input wire sbp_pkg::sbp_instr_s id_instr_i,
	input wire logic                id_ready_o,
	input wire logic                if_en_o,
	input wire logic                redirect_o,
	input wire logic                discard_o,
	input wire logic                interlock_o,
	input wire logic                stat_write_o,
	input wire sbp_pkg::sbp_ma_s    ma_o,
	input wire sbp_pkg::sbp_wb_s    wb_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	// ------------------------------------------------------------
	// Taken instruction and its class
	// ------------------------------------------------------------
	logic              tk;
	sbp_pkg::sbp_cls_e c;
	assign tk = id_instr_i.valid && id_ready_o;
	assign c  = id_instr_i.cls;

	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	property p_call;
		tk && c inside {sbp_pkg::CLS_CALL_PCREL, sbp_pkg::CLS_CALL_PCREG, sbp_pkg::CLS_CALL_IND}
		|=> redirect_o && discard_o && !id_ready_o ##1 !redirect_o
		##1 wb_o.en && wb_o.kind == sbp_pkg::WBK_RA && wb_o.idx == $past(id_instr_i.dst, 3);
	endproperty
	a_call: assert property (p_call) else $error("call sequence wrong");

	property p_alu;
		tk && c == sbp_pkg::CLS_CTL_ALU |=> ##1 !ma_o.req
		##1 wb_o.en && wb_o.kind == sbp_pkg::WBK_CTL && wb_o.idx == $past(id_instr_i.dst, 3);
	endproperty
	a_alu: assert property (p_alu) else $error("control move write-back wrong");

	property p_dsp_alu;
		dsp_mode_i && tk && c inside {sbp_pkg::CLS_CTL_ALU, sbp_pkg::CLS_LOOP_LOAD}
		|=> !id_ready_o [*2] ##1 id_ready_o;
	endproperty
	a_dsp_alu: assert property (p_dsp_alu) else $error("short decode delay wrong");

	property p_flag;
		tk && c == sbp_pkg::CLS_FLAG_OP
		|=> (!(id_instr_i.valid && id_instr_i.reads_stat) || !id_ready_o) [*2]
		##1 wb_o.en && wb_o.kind == sbp_pkg::WBK_STAT && stat_write_o;
	endproperty
	a_flag: assert property (p_flag) else $error("flag update wrong");

	property p_tlb;
		tk && c == sbp_pkg::CLS_TLB_LOAD |=> ##1 ma_o.req && !ma_o.write ##1 !wb_o.en;
	endproperty
	a_tlb: assert property (p_tlb) else $error("entry load stages wrong");

	property p_nop;
		tk && c == sbp_pkg::CLS_NOP |=> ##1 !ma_o.req ##1 !wb_o.en;
	endproperty
	a_nop: assert property (p_nop) else $error("no-op has extra stages");

	property p_stat_reg;
		tk && c == sbp_pkg::CLS_STAT_LOAD_REG |=> (!if_en_o && !id_ready_o) [*2]
		##1 !if_en_o && stat_write_o ##1 if_en_o;
	endproperty
	a_stat_reg: assert property (p_stat_reg) else $error("status reg load wrong");

	property p_stat_mem;
		tk && c == sbp_pkg::CLS_STAT_LOAD_MEM |=> !id_ready_o ##1 ma_o.req && !if_en_o
		##1 (!if_en_o && !id_ready_o) [*2] ##1 !if_en_o && stat_write_o ##1 if_en_o;
	endproperty
	a_stat_mem: assert property (p_stat_mem) else $error("status mem load wrong");

	property p_ld_use;
		tk && c inside {sbp_pkg::CLS_RA_LOAD_MEM, sbp_pkg::CLS_CTL_LOAD_MEM}
		|=> id_instr_i.valid && (id_instr_i.src_a == $past(id_instr_i.dst)
		|| id_instr_i.src_b == $past(id_instr_i.dst)) |-> interlock_o && !id_ready_o;
	endproperty
	a_ld_use: assert property (p_ld_use) else $error("load-use not held");

	property p_ma_fetch;
		ma_o.req |-> !if_en_o;
	endproperty
	a_ma_fetch: assert property (p_ma_fetch) else $error("fetch during data access");

	property p_store;
		tk && c == sbp_pkg::CLS_RA_STORE_MEM |=> ##1 ma_o.req && ma_o.write
		##1 wb_o.en && wb_o.kind == sbp_pkg::WBK_PTR && wb_o.idx == $past(id_instr_i.ptr, 3);
	endproperty
	a_store: assert property (p_store) else $error("pointer write-back wrong");

	property p_dsp_mem;
		dsp_mode_i && tk && c == sbp_pkg::CLS_CTL_LOAD_MEM |=> !id_ready_o [*4] ##1 id_ready_o;
	endproperty
	a_dsp_mem: assert property (p_dsp_mem) else $error("long decode delay wrong");
endmodule

bind sbp_pipe_ctl sbp_pipe_ctl_assertions chk_u (.ref_clk_i, .rst_i, .dsp_mode_i, .id_instr_i,
	.id_ready_o, .if_en_o, .redirect_o, .discard_o, .interlock_o, .stat_write_o, .ma_o, .wb_o);

`default_nettype wire

// ===== sim/sbp_mem_model.sv
// Memory path model: serves data accesses and watches fetch slots.
// Assumes the sequencer's fetch enable and MA request on one clock.
`timescale 1ns/1ns
`default_nettype none

module sbp_mem_model (
	input  wire logic             ref_clk_i,
	input  wire logic             rst_i,
	input  wire logic             if_en_i,
	input  wire sbp_pkg::sbp_ma_s ma_i,
	output int                    data_cnt_o,
	output int                    clash_cnt_o
);
	// Count served data accesses and slots shared with a fetch
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			data_cnt_o  <= 0;
			clash_cnt_o <= 0;
		end else begin
			if (ma_i.req === 1'b1)
				data_cnt_o <= data_cnt_o + 1;
			if (ma_i.req === 1'b1 && if_en_i !== 1'b0)
				clash_cnt_o <= clash_cnt_o + 1;
		end
	end
endmodule

`default_nettype wire

// ===== sim/tb_top.sv
// Self-checking bench for the call and system-control sequencer.
// Assumes the checker and memory path model are compiled first.
`timescale 1ns/1ns
`default_nettype none

module tb_top;
	logic                ref_clk_i  = 1'b0;
	logic                rst_i      = 1'b1;
	logic                dsp_mode_i = 1'b0;
	sbp_pkg::sbp_instr_s id_instr_i = '0;
	logic                id_ready_o, if_en_o, redirect_o, discard_o, interlock_o, stat_write_o;
	sbp_pkg::sbp_ma_s    ma_o;
	sbp_pkg::sbp_wb_s    wb_o;
	int                  data_cnt, clash_cnt, w;
	logic                ilk;
	int                  mismatches  = 0;
	int                  check_count = 0;

	// Core clock, 100 ns period
	always #50 ref_clk_i = ~ref_clk_i;

	sbp_pipe_ctl dut_u (.ref_clk_i, .rst_i, .dsp_mode_i,
		.id_instr_i, .id_ready_o, .if_en_o, .redirect_o, .discard_o, .interlock_o,
		.stat_write_o, .ma_o, .wb_o);

	sbp_mem_model mem_u (.ref_clk_i, .rst_i, .if_en_i(if_en_o), .ma_i(ma_o),
		.data_cnt_o(data_cnt), .clash_cnt_o(clash_cnt));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic stop_test;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask

	function automatic sbp_pkg::sbp_instr_s mk(input sbp_pkg::sbp_cls_e c,
			input logic [3:0] d, input logic [3:0] s, input logic r);
		return '{1'b1, c, d, 4'h6, s, 4'hf, r};
	endfunction

	// Present one instruction, count stalled cycles until taken
	task automatic issue(input sbp_pkg::sbp_cls_e c, input logic [3:0] d,
			input logic [3:0] s, input logic r);
		@(posedge ref_clk_i);
		id_instr_i <= mk(c, d, s, r);
		w = 0;
		@(negedge ref_clk_i);
		ilk = interlock_o;
		while (id_ready_o !== 1'b1) begin
			w++;
			if (w > 20) begin
				mismatches++;
				stop_test();
			end
			@(negedge ref_clk_i);
		end
	endtask

	task automatic idle;
		@(posedge ref_clk_i);
		id_instr_i <= '0;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	// Lone instruction: MA slot, then WB slot
	task automatic pipe(input sbp_pkg::sbp_cls_e c, input logic [7:0] ma, input logic [7:0] wb);
		issue(c, 4'h3, 4'h1, 1'b0);
		idle();
		repeat (2) @(negedge ref_clk_i);
		chk({5'h0, ma_o.req, ma_o.write, if_en_o}, ma);
		@(negedge ref_clk_i);
		chk(wb_o.en ? {wb_o.en, wb_o.kind, wb_o.idx} : 8'h00, wb);
		chk({7'h0, stat_write_o}, {7'h0, c == sbp_pkg::CLS_FLAG_OP});
		repeat (4) @(negedge ref_clk_i);
	endtask

	// Call with its delay slot right behind it
	task automatic calls(input sbp_pkg::sbp_cls_e c);
		issue(c, 4'h3, 4'h1, 1'b0);
		@(posedge ref_clk_i);
		id_instr_i <= mk(sbp_pkg::CLS_NOP, 4'h0, 4'h1, 1'b0);
		@(negedge ref_clk_i);
		chk({5'h0, redirect_o, discard_o, id_ready_o}, 8'h06);
		@(negedge ref_clk_i);
		chk({5'h0, redirect_o, discard_o, id_ready_o}, 8'h01);
		idle();
		@(negedge ref_clk_i);
		chk({wb_o.en, wb_o.kind, wb_o.idx}, 8'h93);
		repeat (4) @(negedge ref_clk_i);
	endtask

	// Pair back to back, compare stall cycles of the second
	task automatic gap(input sbp_pkg::sbp_cls_e a, input sbp_pkg::sbp_cls_e b,
			input logic [3:0] s, input logic r, input logic [7:0] exp);
		logic hz;
		issue(a, 4'h2, 4'h1, 1'b0);
		issue(b, 4'h9, s, r);
		chk(8'(w), exp);
		// Interlock expected when a memory load's destination is read next
		hz = (a == sbp_pkg::CLS_RA_LOAD_MEM || a == sbp_pkg::CLS_CTL_LOAD_MEM) && s == 4'h2;
		chk({7'h0, ilk}, {7'h0, hz});
		idle();
		repeat (8) @(negedge ref_clk_i);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (3) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		@(negedge ref_clk_i);
		chk({1'b0, id_ready_o, if_en_o, redirect_o, discard_o, interlock_o, ma_o.req, wb_o.en},
			8'h60);
		for (int i = 1; i < 4; i++)
			calls(sbp_pkg::sbp_cls_e'(i));
		pipe(sbp_pkg::CLS_NOP, 8'h01, 8'h00);
		pipe(sbp_pkg::CLS_CTL_ALU, 8'h01, 8'ha3);
		pipe(sbp_pkg::CLS_SYS_ALU, 8'h01, 8'h83);
		pipe(sbp_pkg::CLS_FLAG_OP, 8'h01, 8'hb3);
		pipe(sbp_pkg::CLS_TLB_LOAD, 8'h04, 8'h00);
		pipe(sbp_pkg::CLS_RA_LOAD_MEM, 8'h04, 8'h93);
		pipe(sbp_pkg::CLS_CTL_LOAD_MEM, 8'h04, 8'ha3);
		pipe(sbp_pkg::CLS_RA_STORE_MEM, 8'h06, 8'hc6);
		gap(sbp_pkg::CLS_FLAG_OP, sbp_pkg::CLS_NOP, 4'h1, 1'b1, 8'h02);
		gap(sbp_pkg::CLS_FLAG_OP, sbp_pkg::CLS_NOP, 4'h1, 1'b0, 8'h00);
		gap(sbp_pkg::CLS_STAT_LOAD_REG, sbp_pkg::CLS_NOP, 4'h1, 1'b0, 8'h03);
		gap(sbp_pkg::CLS_STAT_LOAD_MEM, sbp_pkg::CLS_NOP, 4'h1, 1'b0, 8'h05);
		gap(sbp_pkg::CLS_RA_LOAD_MEM, sbp_pkg::CLS_SYS_ALU, 4'h2, 1'b0, 8'h01);
		gap(sbp_pkg::CLS_RA_LOAD_MEM, sbp_pkg::CLS_SYS_ALU, 4'h1, 1'b0, 8'h00);
		gap(sbp_pkg::CLS_CTL_LOAD_MEM, sbp_pkg::CLS_SYS_ALU, 4'h2, 1'b0, 8'h01);
		gap(sbp_pkg::CLS_CTL_ALU, sbp_pkg::CLS_NOP, 4'h1, 1'b0, 8'h00);
		@(posedge ref_clk_i);
		dsp_mode_i <= 1'b1;
		gap(sbp_pkg::CLS_CTL_ALU, sbp_pkg::CLS_NOP, 4'h1, 1'b0, 8'h02);
		gap(sbp_pkg::CLS_LOOP_LOAD, sbp_pkg::CLS_NOP, 4'h1, 1'b0, 8'h02);
		gap(sbp_pkg::CLS_CTL_LOAD_MEM, sbp_pkg::CLS_NOP, 4'h1, 1'b0, 8'h04);
		chk(8'(data_cnt), 8'h09);
		chk(8'(clash_cnt), 8'h00);
		stop_test();
	end
endmodule

`default_nettype wire
